/* File: core/dccr_defines.vh */
// Purpose: constants for the DAC channel control register bank
// Assumes: register index times four gives the AXI byte address
// Notes: some numbers carry several names; included by the bank
//
// Summary of operation
// - Power bit 4 set puts the converter core to sleep, clear keeps it running.
// - Power bit 0 set puts the output amplifier to sleep, apart from the core bit.
// - All power bits are zero after reset, so core and amplifier start running.
// - Span codes 000..100 select 0-2.5, 0-5, 0-10, -5..+5 and -2.5..+7.5 V.
// - The span register resets to zero and its upper four bits are read-only.
// - With the strobe mask clear, a strobe assertion loads staged data to output.
// - With the strobe mask set, strobe assertions leave the output code alone.
// - The 16-bit output code register is read/write, holds the driven code, resets to 0.
// - A direct page write is copied into the output code when the route bit is 1.
// - A staging page write is copied into the staging register when the route bit is 1.
// - The route bit resets to 0 and gates both page copies.
// - Staging moves to output on strobe, software load command or auto transfer.
`ifndef DCCR_DEFINES_VH
`define DCCR_DEFINES_VH

`define DCCR_IDX_PWR    8'h18
`define DCCR_IDX_SPAN   8'h19
`define DCCR_IDX_AUTO   8'h20
`define DCCR_IDX_MASK   8'h28
`define DCCR_IDX_OUT    8'h29
`define DCCR_IDX_DPAGE  8'h2d
`define DCCR_IDX_ROUTE  8'h2f
`define DCCR_IDX_SPAGE  8'h30
`define DCCR_IDX_SWLD   8'h32
`define DCCR_IDX_STAGE  8'h33

`define DCCR_BIT_CORE   4
`define DCCR_BIT_AMP    0
`define DCCR_BIT_CTL    0
`define DCCR_SPAN_W     4

`define DCCR_RST_BIT    1'b0
`define DCCR_RST_SPAN   4'h0
`define DCCR_RST_CODE   16'h0000

`define DCCR_SPAN_2V5   4'h0
`define DCCR_SPAN_5V    4'h1
`define DCCR_SPAN_10V   4'h2
`define DCCR_SPAN_PM5   4'h3
`define DCCR_SPAN_OFF   4'h4

`define DCCR_RESP_OKAY  2'b00
`define DCCR_RESP_SLV   2'b10

`endif

/* File: core/dccr_regs.v */
// Purpose: AXI4-Lite register bank for one DAC output channel
// Assumes: load_strobe_n is asynchronous, active low
// Notes: outputs are registered; span one-hot lags the field by one cycle
`timescale 1ns/1ns
`include "dccr_defines.vh"

module dccr_regs #(
  parameter ADDR_W = 10
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // External load strobe
  input  wire              load_strobe_n,
  // Channel controls
  output reg               core_sleep,
  output reg               amp_sleep,
  output reg  [4:0]        span_sel,
  output reg  [15:0]       dac_code
);

  // Register fields
  reg        core_sleep_bit;
  reg        amplifier_sleep_bit;
  reg [3:0]  span_code_field;
  reg        load_strobe_mask_bit;
  reg [15:0] output_code_field;
  reg [15:0] direct_page;
  reg        copy_route_bit;
  reg [15:0] staging_page;
  reg [15:0] staging_input_register;
  reg        auto_xfer_bit;

  // Write channel holding
  reg              aw_full;
  reg [ADDR_W-1:0] aw_addr;
  reg              w_full;
  reg [31:0]       w_data;
  reg [3:0]        w_strb;

  // Strobe synchroniser
  reg ls_meta;
  reg ls_sync;
  reg ls_prev;

  // Next values
  reg        next_aw_full;
  reg        next_w_full;
  reg [15:0] next_out;
  reg [15:0] next_stage;
  reg        stage_wr;
  reg        wr_hit;
  reg [31:0] rd_word;
  reg        rd_hit;
  reg [4:0]  next_span_sel;

  wire [7:0] widx;
  wire [7:0] ridx;
  wire       do_wr;
  wire       aw_take;
  wire       w_take;
  wire       ar_take;
  wire       strobe_edge;
  wire       load_evt;

  assign widx    = aw_addr[9:2];
  assign ridx    = s_axi_araddr[9:2];
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  // Held halves commit only once the previous response is gone
  assign do_wr   = aw_full & w_full & ~s_axi_bvalid;

  // Byte-lane merge into a 16-bit field
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge16[7:0]  = s[0] ? d[7:0]  : old[7:0];
      merge16[15:8] = s[1] ? d[15:8] : old[15:8];
    end
  endfunction

  // Assertion is the high-to-low step of the synchronised strobe
  assign strobe_edge = ls_prev & ~ls_sync;
  assign load_evt    = strobe_edge & ~load_strobe_mask_bit;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ls_meta <= 1'b1;
      ls_sync <= 1'b1;
      ls_prev <= 1'b1;
    end else begin
      ls_meta <= load_strobe_n;
      ls_sync <= ls_meta;
      ls_prev <= ls_sync;
    end
  end

  // Holding flags for address and data
  always @* begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    if (do_wr) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
    end
    if (aw_take) begin
      next_aw_full = 1'b1;
    end
    if (w_take) begin
      next_w_full = 1'b1;
    end
  end

  // Code path: bus writes are applied after a strobe load so they win
  always @* begin
    next_out   = output_code_field;
    next_stage = staging_input_register;
    stage_wr   = 1'b0;
    if (load_evt) begin
      next_out = staging_input_register;
    end
    if (do_wr) begin
      case (widx)
        `DCCR_IDX_OUT: begin
          next_out = merge16(output_code_field, w_data, w_strb);
        end
        `DCCR_IDX_DPAGE: begin
          if (copy_route_bit) begin
            next_out = merge16(direct_page, w_data, w_strb);
          end
        end
        `DCCR_IDX_SPAGE: begin
          if (copy_route_bit) begin
            next_stage = merge16(staging_page, w_data, w_strb);
            stage_wr   = 1'b1;
          end
        end
        `DCCR_IDX_STAGE: begin
          next_stage = merge16(staging_input_register, w_data, w_strb);
          stage_wr   = 1'b1;
        end
        `DCCR_IDX_SWLD: begin
          if (w_strb[0] && w_data[`DCCR_BIT_CTL]) begin
            next_out = staging_input_register;
          end
        end
        default: begin
          next_out = next_out;
        end
      endcase
    end
    // Auto transfer forwards every new staging value
    if (stage_wr && auto_xfer_bit) begin
      next_out = next_stage;
    end
  end

  // Write address decode for the response code
  always @* begin
    case (widx)
      `DCCR_IDX_PWR,
      `DCCR_IDX_SPAN,
      `DCCR_IDX_AUTO,
      `DCCR_IDX_MASK,
      `DCCR_IDX_OUT,
      `DCCR_IDX_DPAGE,
      `DCCR_IDX_ROUTE,
      `DCCR_IDX_SPAGE,
      `DCCR_IDX_SWLD,
      `DCCR_IDX_STAGE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Read mux; reserved bits are zero
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (ridx)
      `DCCR_IDX_PWR: begin
        rd_word[`DCCR_BIT_CORE] = core_sleep_bit;
        rd_word[`DCCR_BIT_AMP]  = amplifier_sleep_bit;
      end
      `DCCR_IDX_SPAN: begin
        rd_word[3:0] = span_code_field;
      end
      `DCCR_IDX_AUTO: begin
        rd_word[`DCCR_BIT_CTL] = auto_xfer_bit;
      end
      `DCCR_IDX_MASK: begin
        rd_word[`DCCR_BIT_CTL] = load_strobe_mask_bit;
      end
      `DCCR_IDX_OUT: begin
        rd_word[15:0] = output_code_field;
      end
      `DCCR_IDX_DPAGE: begin
        rd_word[15:0] = direct_page;
      end
      `DCCR_IDX_ROUTE: begin
        rd_word[`DCCR_BIT_CTL] = copy_route_bit;
      end
      `DCCR_IDX_SPAGE: begin
        rd_word[15:0] = staging_page;
      end
      `DCCR_IDX_SWLD: begin
        // Command bit is not stored, so it always reads zero
        rd_word = 32'h0000_0000;
      end
      `DCCR_IDX_STAGE: begin
        rd_word[15:0] = staging_input_register;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Span decode; codes above the last span select nothing
  always @* begin
    case (span_code_field)
      `DCCR_SPAN_2V5: next_span_sel = 5'h01;
      `DCCR_SPAN_5V:  next_span_sel = 5'h02;
      `DCCR_SPAN_10V: next_span_sel = 5'h04;
      `DCCR_SPAN_PM5: next_span_sel = 5'h08;
      `DCCR_SPAN_OFF: next_span_sel = 5'h10;
      default:        next_span_sel = 5'h00;
    endcase
  end

  // Bus handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= {ADDR_W{1'b0}};
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DCCR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `DCCR_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= ~next_aw_full;
      s_axi_wready  <= ~next_w_full;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `DCCR_RESP_OKAY : `DCCR_RESP_SLV;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_take) begin
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? `DCCR_RESP_OKAY : `DCCR_RESP_SLV;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else begin
        s_axi_arready <= ~s_axi_rvalid;
      end
    end
  end

  // Control registers; partial strobes only touch the lanes given
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_sleep_bit         <= `DCCR_RST_BIT;
      amplifier_sleep_bit    <= `DCCR_RST_BIT;
      span_code_field        <= `DCCR_RST_SPAN;
      load_strobe_mask_bit   <= `DCCR_RST_BIT;
      auto_xfer_bit          <= `DCCR_RST_BIT;
      copy_route_bit         <= `DCCR_RST_BIT;
      output_code_field      <= `DCCR_RST_CODE;
      direct_page            <= `DCCR_RST_CODE;
      staging_page           <= `DCCR_RST_CODE;
      staging_input_register <= `DCCR_RST_CODE;
    end else begin
      output_code_field      <= next_out;
      staging_input_register <= next_stage;
      if (do_wr && w_strb[0]) begin
        case (widx)
          `DCCR_IDX_PWR: begin
            core_sleep_bit      <= w_data[`DCCR_BIT_CORE];
            amplifier_sleep_bit <= w_data[`DCCR_BIT_AMP];
          end
          `DCCR_IDX_SPAN: begin
            span_code_field <= w_data[3:0];
          end
          `DCCR_IDX_AUTO: begin
            auto_xfer_bit <= w_data[`DCCR_BIT_CTL];
          end
          `DCCR_IDX_MASK: begin
            load_strobe_mask_bit <= w_data[`DCCR_BIT_CTL];
          end
          `DCCR_IDX_ROUTE: begin
            copy_route_bit <= w_data[`DCCR_BIT_CTL];
          end
          default: begin
            copy_route_bit <= copy_route_bit;
          end
        endcase
      end
      if (do_wr && widx == `DCCR_IDX_DPAGE) begin
        direct_page <= merge16(direct_page, w_data, w_strb);
      end
      if (do_wr && widx == `DCCR_IDX_SPAGE) begin
        staging_page <= merge16(staging_page, w_data, w_strb);
      end
    end
  end

  // Pin-facing outputs, one flop each
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_sleep <= 1'b0;
      amp_sleep  <= 1'b0;
      span_sel   <= 5'h01;
      dac_code   <= 16'h0000;
    end else begin
      core_sleep <= core_sleep_bit;
      amp_sleep  <= amplifier_sleep_bit;
      span_sel   <= next_span_sel;
      dac_code   <= output_code_field;
    end
  end

endmodule

/* File: verification/dccr_regs_asserts.sv */
// Purpose: port-level checks of the channel register bank
// Assumes: one clock, synchronous active-low reset
// Notes: control outputs move only around a committed write; the output code may also move after a strobe
`timescale 1ns/1ns
`include "dccr_defines.vh"
module dccr_regs_asserts (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Channel side
  input wire        load_strobe_n,
  input wire        core_sleep,
  input wire        amp_sleep,
  input wire [4:0]  span_sel,
  input wire [15:0] dac_code
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Address side stays refused for the cycle the pair is held; ready may return with the response
  sequence wr_done;
    ##1 !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_ctrl_quiet: assert property (!s_axi_bvalid && !$past(s_axi_bvalid) |->
    $stable({core_sleep, amp_sleep, span_sel})) else $error("control output moved without a write");
  a_span_onehot: assert property ($onehot0(span_sel)) else $error("span select not one-hot");
  a_code_cause: assert property ($changed(dac_code) |->
    $past(s_axi_bvalid) || !$past(load_strobe_n, 4)) else $error("output code moved without cause");
  a_write_lat: assert property (wr_take |-> wr_done) else $error("write response late");
  a_read_lat: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready) else $error("read data late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `DCCR_RESP_SLV |->
    s_axi_rdata == 32'h0) else $error("error read returned data");
endmodule
bind dccr_regs dccr_regs_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .load_strobe_n, .core_sleep, .amp_sleep, .span_sel, .dac_code);

/* File: verification/dccr_host.sv */
// Purpose: AXI4-Lite host that writes and reads the register map
// Assumes: one write or one read under way at a time
// Notes: stall holds off bready/rready three cycles to test held answers
`timescale 1ns/1ns
module dccr_host (
  // Clock and pacing
  input wire        aclk,
  input wire        stall,
  // Bus
  output reg [9:0]  s_axi_awaddr = 10'h0,
  output reg        s_axi_awvalid = 1'b0,
  input wire        s_axi_awready,
  output reg [31:0] s_axi_wdata = 32'h0,
  output reg [3:0]  s_axi_wstrb = 4'h0,
  output reg        s_axi_wvalid = 1'b0,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  output reg        s_axi_bready = 1'b0,
  output reg [9:0]  s_axi_araddr = 10'h0,
  output reg        s_axi_arvalid = 1'b0,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  output reg        s_axi_rready = 1'b0
);
  task wr(input [9:0] a, input [31:0] d, output [1:0] r);
    integer n;
    begin
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !stall;
      do begin
        @(posedge aclk);
        n = n + 1;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (n == 3 && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // Released payload must not look like the last value
      s_axi_wdata <= ~d;
      s_axi_awaddr <= ~a;
    end
  endtask
  task rd(input [9:0] a, output [31:0] d, output [1:0] r);
    integer n;
    begin
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !stall;
      do begin
        @(posedge aclk);
        n = n + 1;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (n == 3 && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      s_axi_araddr <= ~a;
    end
  endtask
endmodule

/* File: verification/dccr_regs_tb.sv */
// Purpose: self-checking bench for the channel register bank
// Assumes: byte address is four times the register index
// Notes: random data from a fixed seed, corner values mixed in
`timescale 1ns/1ns
`include "dccr_defines.vh"
module dccr_regs_tb;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg         load_strobe_n = 1'b1;
  reg         stall = 1'b0;
  wire [9:0]  s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0]  s_axi_wstrb;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, core_sleep, amp_sleep;
  wire [4:0]  span_sel;
  wire [15:0] dac_code;
  integer     failures = 0, comparisons = 0, seed = 64914, i;
  reg [31:0]  d, q, x, y;
  reg [1:0]   r;
  localparam [71:0] reg_map = {`DCCR_IDX_PWR, `DCCR_IDX_SPAN, `DCCR_IDX_MASK, `DCCR_IDX_OUT, `DCCR_IDX_DPAGE,
    `DCCR_IDX_ROUTE, `DCCR_IDX_SPAGE, `DCCR_IDX_SWLD, `DCCR_IDX_STAGE};
  dccr_host u_host (.aclk, .stall, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dccr_regs u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .load_strobe_n, .core_sleep,
    .amp_sleep, .span_sel, .dac_code);
  function [4:0] span_exp(input [3:0] c);
    span_exp = (c < 4'h5) ? (5'h01 << c) : 5'h00;
  endfunction
  task end_sim;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rc(input [7:0] idx, input [31:0] exp);
    begin
      u_host.rd({idx, 2'b00}, q, r);
      cmp(q, exp);
      cmp(r, `DCCR_RESP_OKAY);
    end
  endtask
  task wv(input [7:0] idx, input [31:0] v);
    begin
      u_host.wr({idx, 2'b00}, v, r);
      cmp(r, `DCCR_RESP_OKAY);
    end
  endtask
  // Settle past the one-cycle output lag, then sample off the edge
  task wt;
    begin
      repeat (2) @(posedge aclk);
      #1;
    end
  endtask
  // Held low long enough to pass the pin synchroniser
  task strobe;
    begin
      @(posedge aclk);
      load_strobe_n <= 1'b0;
      repeat (6) @(posedge aclk);
      load_strobe_n <= 1'b1;
      @(posedge aclk);
    end
  endtask
  initial forever #5 aclk = ~aclk;
  initial begin
    #100000;
    failures = failures + 1;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp({core_sleep, amp_sleep, span_sel, dac_code}, {2'b00, 5'h01, 16'h0000});
    for (i = 0; i < 9; i = i + 1) rc(reg_map[i*8 +: 8], 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      d = (i == 0) ? 32'h10 : (i == 1) ? 32'h01 : (i == 2) ? 32'hff : $random(seed);
      stall <= $random(seed);
      wv(`DCCR_IDX_PWR, d);
      rc(`DCCR_IDX_PWR, d & 32'h11);
      wt;
      cmp({core_sleep, amp_sleep}, {d[4], d[0]});
    end
    for (i = 0; i < 16; i = i + 1) begin
      wv(`DCCR_IDX_SPAN, ($random(seed) << 4) | i);
      rc(`DCCR_IDX_SPAN, i);
      wt;
      cmp(span_sel, span_exp(i[3:0]));
    end
    d = $random(seed);
    x = $random(seed) & 32'hffff;
    y = $random(seed) & 32'hffff;
    wv(`DCCR_IDX_OUT, d);
    rc(`DCCR_IDX_OUT, d[15:0]);
    wt;
    cmp(dac_code, d[15:0]);
    wv(`DCCR_IDX_DPAGE, x);
    rc(`DCCR_IDX_DPAGE, x);
    rc(`DCCR_IDX_OUT, d[15:0]);
    wv(`DCCR_IDX_SPAGE, y);
    rc(`DCCR_IDX_STAGE, 32'h0);
    wv(`DCCR_IDX_ROUTE, 32'hff);
    rc(`DCCR_IDX_ROUTE, 32'h1);
    wv(`DCCR_IDX_DPAGE, x);
    rc(`DCCR_IDX_OUT, x);
    wv(`DCCR_IDX_SPAGE, y);
    rc(`DCCR_IDX_STAGE, y);
    strobe;
    rc(`DCCR_IDX_OUT, y);
    cmp(dac_code, y);
    wv(`DCCR_IDX_MASK, 32'h1);
    wv(`DCCR_IDX_OUT, x);
    strobe;
    rc(`DCCR_IDX_OUT, x);
    wv(`DCCR_IDX_SWLD, 32'h1);
    rc(`DCCR_IDX_OUT, y);
    rc(`DCCR_IDX_SWLD, 32'h0);
    // Auto transfer: a direct staging write must reach the output at once
    wv(`DCCR_IDX_AUTO, 32'hff);
    rc(`DCCR_IDX_AUTO, 32'h1);
    wv(`DCCR_IDX_STAGE, d);
    rc(`DCCR_IDX_STAGE, d[15:0]);
    rc(`DCCR_IDX_OUT, d[15:0]);
    wt;
    cmp(dac_code, d[15:0]);
    stall <= 1'b1;
    u_host.wr(10'h3fc, 32'h1, r);
    cmp(r, `DCCR_RESP_SLV);
    u_host.rd(10'h3fc, q, r);
    cmp(q, 32'h0);
    cmp(r, `DCCR_RESP_SLV);
    end_sim;
  end
endmodule
